/* dv/power_mode_and_brownout_control_test.sv */
// Purpose: Self-checking bench for the power mode controller
// Assumes: Zero-wait APB; restart timer shortened to WC cycles
// Notes:   Detector trips and external interrupt lines come from the partner model
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_brownout_control_test;
   import pmu_pkg::*;
   localparam int WC = 8;
   logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr;
   logic        err, fixedDetTrip, sysFlagIrq, sysResetReq, cpuClkEn;
   logic        oscEnable, flashPowerOn, selDetPowerOn, slowMode;
   logic        subClockMode, lowSpeedOscEn;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0]  supplyDv;
   logic [4:0]  srcV;
   logic [3:0]  selDetTrip;
   logic [2:0]  extIrqActive, extIrqLevelMode, sysClockDivSel;
   logic [1:0]  oscSourceSel;
   int          miscompares = 0, checks = 0, rstCnt = 0, n, snap;
   logic [11:0] en [8] = '{12'h008, 12'h040, 12'h080, 12'hd01,
                           12'h000, 12'h005, 12'h000, 12'h005};
   logic [7:0]  bod [8] = '{8'h35, 8'h35, 8'h35, 8'h35,
                            8'h35, 8'h85, 8'h35, 8'h0d};
   int          src [8] = '{0, 1, 2, 3, 4, 5, 2, 5};
   logic [31:0] fl [8] = '{0, 0, 0, 1, 0, 4, 0, 0};
   logic [5:0]  thr [4] = '{6'h14, 6'h18, 6'h25, 6'h2a};

   supply_wake_model partner (
      .sys_clk(sys_clk), .srst(srst), .supplyDv(supplyDv),
      .wakeReq({2'h0, srcV[0]}), .cpuClkEn(cpuClkEn),
      .fixedDetTrip(fixedDetTrip), .selDetTrip(selDetTrip),
      .extIrqActive(extIrqActive)
   );
   power_mode_and_brownout_control #(.WAKE_CYCLES(WC)) uut (
      .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .fixedDetTrip(fixedDetTrip),
      .selDetTrip(selDetTrip), .extIrqActive(extIrqActive),
      .keypadMatch(srcV[1]), .rtcOverflow(srcV[2]), .wdOverflow(srcV[3]),
      .resetPin(srcV[4]), .cpuIrqTaken(1'b0), .sysFlagIrq(sysFlagIrq),
      .sysResetReq(sysResetReq), .cpuClkEn(cpuClkEn),
      .oscEnable(oscEnable), .flashPowerOn(flashPowerOn),
      .selDetPowerOn(selDetPowerOn), .extIrqLevelMode(extIrqLevelMode),
      .sysClockDivSel(sysClockDivSel), .oscSourceSel(oscSourceSel),
      .slowMode(slowMode), .subClockMode(subClockMode),
      .lowSpeedOscEn(lowSpeedOscEn)
   );

   // Clock at 20 MHz
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Count system reset requests
   always @(posedge sys_clk) begin
      if (sysResetReq === 1'b1) begin
         rstCnt <= rstCnt + 1;
      end
   end
   // Compare one result and count it
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(rd, e);
   endtask : rdc
   // Wait a bounded time for the CPU clock to return
   task automatic waitRun(input int lim);
      n = 0;
      while (cpuClkEn !== 1'b1 && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
   endtask : waitRun
   // Power-down with one wake source; case 6 and 7 must not wake
   task automatic pdTry(input int i);
      wr(BODCTL_OFS, {24'h0, bod[i]});
      wr(ENABLE_OFS, {20'h0, en[i]});
      repeat (80) @(posedge sys_clk);
      wr(MODE_OFS, 32'h2);
      repeat (2) @(negedge sys_clk);
      cmp({oscEnable, flashPowerOn, cpuClkEn}, 0);
      cmp(extIrqLevelMode, en[i][5:3]);
      snap = rstCnt;
      @(posedge sys_clk);
      if (src[i] == 5) begin
         supplyDv <= 6'h13;
      end else begin
         srcV[src[i]] <= 1'b1;
      end
      repeat (WC) @(negedge sys_clk);
      cmp(cpuClkEn, 0);
      if (src[i] == 4) begin
         repeat (WC) @(negedge sys_clk);
         cmp(cpuClkEn, 0);
      end
      if (i > 5) begin
         cmp(rstCnt, snap);
         rdc(STATE_OFS, 32'h4);
         srcV <= 5'h10;
         supplyDv <= 6'h2d;
      end
      repeat (WC + 4) @(posedge sys_clk);
      srcV <= 5'h0;
      supplyDv <= 6'h2d;
      waitRun(40);
      cmp(cpuClkEn, 1);
      rdc(FLAG_OFS, fl[i]);
      wr(FLAG_OFS, 32'h7);
   endtask : pdTry
   // Print counts and verdict, then stop
   task automatic test_done;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   // Cut a hang short
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      test_done();
   end
   // Main sequence
   initial begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      srcV = 5'h0;
      supplyDv = 6'h2d;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      rdc(BODCTL_OFS, 32'h35);
      rdc(ENABLE_OFS, 32'h0);
      rdc(STATE_OFS, 32'h1);
      rdc(FLAG_OFS, 32'h0);
      rdc(12'h020, 32'h0);
      cmp(err, 1);
      wr(BODCTL_OFS, 32'h40);
      supplyDv <= 6'h13;
      rdc(BODCTL_OFS, 32'h1);
      cmp(selDetPowerOn, 0);
      rdc(FLAG_OFS, 32'h0);
      wr(BODCTL_OFS, 32'h35);
      supplyDv <= 6'h10;
      wr(ENABLE_OFS, 32'h3);
      rdc(FLAG_OFS, 32'h6);
      supplyDv <= 6'h2d;
      @(negedge sys_clk);
      cmp(sysFlagIrq, 1);
      wr(ENABLE_OFS, 32'h1);
      @(negedge sys_clk);
      cmp(sysFlagIrq, 0);
      wr(ENABLE_OFS, 32'h4);
      @(negedge sys_clk);
      cmp(sysFlagIrq, 0);
      wr(ENABLE_OFS, 32'h5);
      @(negedge sys_clk);
      cmp(sysFlagIrq, 1);
      wr(FLAG_OFS, 32'h0);
      rdc(FLAG_OFS, 32'h6);
      wr(FLAG_OFS, 32'h2);
      rdc(FLAG_OFS, 32'h4);
      wr(FLAG_OFS, 32'h4);
      for (int k = 0; k < 4; k++) begin
         wr(BODCTL_OFS, {26'h0, k[1:0], 4'h5});
         supplyDv <= thr[k] + 6'h1;
         rdc(FLAG_OFS, 32'h0);
         supplyDv <= thr[k];
         rdc(FLAG_OFS, 32'h4);
         supplyDv <= 6'h2d;
         wr(FLAG_OFS, 32'h4);
      end
      wr(BODCTL_OFS, 32'h3d);
      snap = rstCnt;
      supplyDv <= 6'h29;
      repeat (6) @(negedge sys_clk);
      cmp(rstCnt > snap, 1);
      rdc(FLAG_OFS, 32'h4);
      supplyDv <= 6'h2d;
      wr(BODCTL_OFS, 32'h37);
      snap = rstCnt;
      supplyDv <= 6'h10;
      repeat (6) @(negedge sys_clk);
      cmp(rstCnt > snap, 1);
      rdc(FLAG_OFS, 32'h6);
      supplyDv <= 6'h2d;
      wr(BODCTL_OFS, 32'h35);
      wr(FLAG_OFS, 32'h7);
      wr(CLKSEL_OFS, 32'h23);
      @(negedge sys_clk);
      cmp({slowMode, subClockMode, lowSpeedOscEn, sysClockDivSel,
           oscSourceSel}, 32'hee);
      wr(CLKSEL_OFS, 32'h0);
      @(negedge sys_clk);
      cmp(slowMode, 0);
      wr(ENABLE_OFS, 32'h8);
      wr(MODE_OFS, 32'h1);
      repeat (2) @(negedge sys_clk);
      cmp({cpuClkEn, oscEnable}, 32'h1);
      rdc(STATE_OFS, 32'h2);
      srcV <= 5'h1;
      @(posedge sys_clk);
      srcV <= 5'h0;
      waitRun(30);
      cmp(cpuClkEn, 1);
      rdc(STATE_OFS, 32'h1);
      rdc(MODE_OFS, 32'h0);
      for (int i = 0; i < 8; i++) begin
         pdTry(i);
      end
      test_done();
   end
endmodule : power_mode_and_brownout_control_test
`default_nettype wire

/* dv/supply_wake_model.sv */
// Purpose: Supply and wake-line model facing the power controller
// Assumes: Supply level is given in tenths of a volt
// Notes:   A wake line is held until the CPU clock returns
`timescale 1ns/1ps
`default_nettype none
module supply_wake_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       srst,
   // Stimulus from the bench
   input  wire logic [5:0] supplyDv,
   input  wire logic [2:0] wakeReq,
   input  wire logic       cpuClkEn,
   // Detector and wake lines
   output logic            fixedDetTrip,
   output logic [3:0]      selDetTrip,
   output logic [2:0]      extIrqActive
);
   // Each detector trips at or below its level
   always_comb begin
      fixedDetTrip  = supplyDv <= 6'h11;
      selDetTrip[0] = supplyDv <= 6'h14;
      selDetTrip[1] = supplyDv <= 6'h18;
      selDetTrip[2] = supplyDv <= 6'h25;
      selDetTrip[3] = supplyDv <= 6'h2a;
   end
   // Wake line stays active until execution resumes
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         extIrqActive <= 3'h0;
      end else begin
         extIrqActive <= wakeReq | (extIrqActive & {3{~cpuClkEn}});
      end
   end
endmodule : supply_wake_model
`default_nettype wire

/* hdl/pmu_pkg.sv */
// Purpose: Shared constants for the power mode and brown-out controller
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   All offsets are byte addresses
package pmu_pkg;
   // Register byte offsets
   localparam logic [11:0] MODE_OFS   = 12'h000;
   localparam logic [11:0] FLAG_OFS   = 12'h004;
   localparam logic [11:0] BODCTL_OFS = 12'h008;
   localparam logic [11:0] ENABLE_OFS = 12'h00c;
   localparam logic [11:0] CLKSEL_OFS = 12'h010;
   localparam logic [11:0] STATE_OFS  = 12'h014;
   // Mode register fields
   localparam int IDLE_BIT  = 0;
   localparam int PDOWN_BIT = 1;
   // Flag register fields
   localparam int WDF_BIT   = 0;
   localparam int FBF_BIT   = 1;
   localparam int SBF_BIT   = 2;
   // Brown-out control fields
   localparam int FBRE_BIT  = 1;
   localparam int SDEN_BIT  = 2;
   localparam int SBRE_BIT  = 3;
   localparam int THR_LSB   = 4;
   localparam int AWAKE_BIT = 7;
   // Enable register fields
   localparam int SFIE_BIT  = 0;
   localparam int FBIE_BIT  = 1;
   localparam int SBIE_BIT  = 2;
   localparam int EXIE_LSB  = 3;
   localparam int KBIE_BIT  = 6;
   localparam int RTCIE_BIT = 7;
   localparam int WDIE_BIT  = 8;
   localparam int WDRE_BIT  = 9;
   localparam int NSW_BIT   = 10;
   localparam int WDEN_BIT  = 11;
   // Clock select fields
   localparam int DIV_LSB   = 0;
   localparam int OSC_LSB   = 4;
   // Reset values
   localparam logic [7:0]  BODCTL_RST = 8'h35;
   localparam logic [11:0] ENABLE_RST = 12'h000;
   // Threshold codes and low-speed oscillator select code
   localparam logic [1:0] THR_2V0 = 2'h0;
   localparam logic [1:0] THR_2V4 = 2'h1;
   localparam logic [1:0] THR_3V7 = 2'h2;
   localparam logic [1:0] THR_4V2 = 2'h3;
   localparam logic [1:0] OSC_LOW_SPEED = 2'h2;
   // Timing
   localparam int CLK_HZ     = 20_000_000;
   localparam int WAKE_COUNT = 1024;
   typedef enum logic [3:0] {
      ST_RUN   = 4'b0001,
      ST_IDLE  = 4'b0010,
      ST_PDOWN = 4'b0100,
      ST_WAKE  = 4'b1000
   } pstate_e;
endpackage : pmu_pkg

/* hdl/power_mode_and_brownout_control.sv */
// Purpose: Power modes, brown-out flags, wake sources, restart timer
// Assumes: Inputs synchronous to sys_clk; detectors give level outputs
// Notes:   Register offsets and field layouts are local choices
// Summary of operation
// - Fixed detector report sets the fixed brown-out flag.
// - Selectable detector, at chosen threshold, sets its flag.
// - Threshold code 00=2.0V 01=2.4V 10=3.7V 11=4.2V.
// - Fixed flag with both enables requests system-flag interrupt.
// - Selectable flag interrupts; wakes power-down when kept awake.
// - Fixed reset enable: event resets system, flag stays set.
// - Selectable reset enable resets; in power-down only if kept awake.
// - Clearing detector enable disables flag, interrupt and reset.
// - Flags clear only on write of one.
// - Non-zero divider select enters slow mode.
// - Oscillator select picks low-speed oscillator for sub-clock mode.
// - RTC overflow wakes power-down when enabled.
// - Watchdog overflow sets flag; with non-stop set it wakes power-down without irq or reset enable.
// - Kept-awake selectable detector wakes power-down.
// - Idle stops CPU clock; peripherals keep running.
// - Idle ends on enabled interrupt or reset.
// - Power-down stops oscillator and flash; RAM kept.
// - Power-down ends only on the listed wake sources.
// - Edge external interrupts become level-sensitive in power-down.
// - Interrupt wake restarts oscillator, gates clock until timer full.
// - Reset pin rising edge ends power-down with timed restart.
// - Keypad match ends power-down via timed restart.
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_brownout_control
   import pmu_pkg::*;
#(
   parameter int WAKE_CYCLES = WAKE_COUNT
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Detectors and wake sources
   input  wire logic        fixedDetTrip,
   input  wire logic [3:0]  selDetTrip,
   input  wire logic [2:0]  extIrqActive,
   input  wire logic        keypadMatch,
   input  wire logic        rtcOverflow,
   input  wire logic        wdOverflow,
   input  wire logic        resetPin,
   input  wire logic        cpuIrqTaken,
   // Outputs to CPU and clock generator
   output logic             sysFlagIrq,
   output logic             sysResetReq,
   output logic             cpuClkEn,
   output logic             oscEnable,
   output logic             flashPowerOn,
   output logic             selDetPowerOn,
   output logic [2:0]       extIrqLevelMode,
   output logic [2:0]       sysClockDivSel,
   output logic [1:0]       oscSourceSel,
   output logic             slowMode,
   output logic             subClockMode,
   output logic             lowSpeedOscEn
);
   import pmu_pkg::*;

   logic [1:0]  modeReq_r;
   logic [2:0]  flags_r;
   logic [7:0]  bodCtl_r;
   logic [11:0] enable_r;
   logic [5:0]  clkSel_r;
   pstate_e     state_r;
   pstate_e     state_nxt;
   logic [15:0] wakeCnt_r;
   logic        resetPinDly_r;
   logic        wrEn;
   logic        rdEn;
   logic        mapped;
   logic        selTrip;
   logic        selActive;
   logic        fixedIrq;
   logic        selIrq;
   logic        anyIrq;
   logic        pdWake;
   logic        wakeDone;
   logic        resetRise;

   // Write-one-to-clear helper
   function automatic logic w1c(input logic cur, input logic set,
                                input logic clr);
      w1c = set | (cur & ~clr);
   endfunction : w1c

   // APB decode, zero wait state
   assign wrEn    = psel & penable & pwrite;
   assign rdEn    = psel & ~pwrite;
   assign pready  = 1'b1;
   assign mapped  = (paddr == MODE_OFS) || (paddr == FLAG_OFS) ||
                    (paddr == BODCTL_OFS) || (paddr == ENABLE_OFS) ||
                    (paddr == CLKSEL_OFS) || (paddr == STATE_OFS);
   assign pslverr = psel & penable & ~mapped;

   // Threshold match, detector on only when enabled and, in power-down, kept awake
   assign selTrip   = selDetTrip[bodCtl_r[THR_LSB +: 2]];
   assign selActive = bodCtl_r[SDEN_BIT] &
                      ((state_r != ST_PDOWN) | bodCtl_r[AWAKE_BIT]);
   assign selDetPowerOn = selActive;

   // Interrupt requests from flags, external lines, keypad, RTC and watchdog
   assign fixedIrq = enable_r[SFIE_BIT] & enable_r[FBIE_BIT] &
                     flags_r[FBF_BIT];
   assign selIrq   = enable_r[SFIE_BIT] & enable_r[SBIE_BIT] &
                     flags_r[SBF_BIT];
   assign sysFlagIrq = fixedIrq | selIrq;
   assign anyIrq = sysFlagIrq | (|(extIrqActive & enable_r[EXIE_LSB +: 3])) |
                   (keypadMatch & enable_r[KBIE_BIT]) |
                   (rtcOverflow & enable_r[RTCIE_BIT]) |
                   (wdOverflow & enable_r[WDIE_BIT] & enable_r[WDEN_BIT]);

   // Power-down wake sources
   assign pdWake =
      (|(extIrqActive & enable_r[EXIE_LSB +: 3])) |
      (keypadMatch & enable_r[KBIE_BIT]) |
      (rtcOverflow & enable_r[RTCIE_BIT]) |
      (wdOverflow & enable_r[WDEN_BIT] & enable_r[NSW_BIT]) |
      (selActive & bodCtl_r[AWAKE_BIT] & flags_r[SBF_BIT] &
       (selIrq | bodCtl_r[SBRE_BIT]));

   assign resetRise = resetPin & ~resetPinDly_r;
   assign wakeDone  = (wakeCnt_r == 16'(WAKE_CYCLES - 1));

   // Reset pin edge history
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         resetPinDly_r <= 1'b0;
      end else begin
         resetPinDly_r <= resetPin;
      end
   end

   // Brown-out and watchdog flags, set beats clear
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flags_r <= 3'h0;
      end else begin
         flags_r[FBF_BIT] <= w1c(flags_r[FBF_BIT], fixedDetTrip,
            wrEn & (paddr == FLAG_OFS) & pwdata[FBF_BIT]);
         flags_r[SBF_BIT] <= w1c(flags_r[SBF_BIT], selTrip & selActive,
            wrEn & (paddr == FLAG_OFS) & pwdata[SBF_BIT]);
         flags_r[WDF_BIT] <= w1c(flags_r[WDF_BIT],
            wdOverflow & enable_r[WDEN_BIT],
            wrEn & (paddr == FLAG_OFS) & pwdata[WDF_BIT]);
      end
   end

   // System reset request; flags are not cleared by it
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sysResetReq <= 1'b0;
      end else begin
         sysResetReq <= (fixedDetTrip & bodCtl_r[FBRE_BIT]) |
            (selTrip & selActive & bodCtl_r[SBRE_BIT]) |
            (wdOverflow & enable_r[WDEN_BIT] & enable_r[WDRE_BIT]);
      end
   end

   // Control registers written from APB
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bodCtl_r <= BODCTL_RST;
         enable_r <= ENABLE_RST;
         clkSel_r <= 6'h00;
      end else if (wrEn) begin
         if (paddr == BODCTL_OFS) begin
            bodCtl_r <= {pwdata[7], 1'b0, pwdata[5:1], 1'b1};
         end
         if (paddr == ENABLE_OFS) begin
            enable_r <= pwdata[11:0];
         end
         if (paddr == CLKSEL_OFS) begin
            clkSel_r <= {pwdata[OSC_LSB +: 2], 1'b0, pwdata[DIV_LSB +: 3]};
         end
      end
   end

   // Idle and power-down request bits, cleared by mode exit
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         modeReq_r <= 2'h0;
      end else if (wrEn && (paddr == MODE_OFS)) begin
         modeReq_r <= pwdata[1:0];
      end else if (state_nxt == ST_RUN || state_nxt == ST_WAKE) begin
         modeReq_r <= 2'h0;
      end
   end

   // Power state sequencing
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN: begin
            if (modeReq_r[PDOWN_BIT]) begin
               state_nxt = ST_PDOWN;
            end else if (modeReq_r[IDLE_BIT]) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (anyIrq || sysResetReq || resetPin) begin
               state_nxt = ST_RUN;
            end
         end
         ST_PDOWN: begin
            if (pdWake || resetRise) begin
               state_nxt = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (wakeDone && !resetPin) begin
               state_nxt = ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Oscillator restart timer
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wakeCnt_r <= 16'h0000;
      end else if (state_r == ST_WAKE) begin
         // Holds at terminal count while the reset pin stays high
         if (!wakeDone) begin
            wakeCnt_r <= wakeCnt_r + 16'h0001;
         end
      end else begin
         wakeCnt_r <= 16'h0000;
      end
   end

   // Clock and power outputs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cpuClkEn     <= 1'b1;
         oscEnable    <= 1'b1;
         flashPowerOn <= 1'b1;
      end else begin
         cpuClkEn     <= (state_nxt == ST_RUN);
         oscEnable    <= (state_nxt != ST_PDOWN);
         flashPowerOn <= (state_nxt != ST_PDOWN);
      end
   end

   // Clock mode outputs
   assign extIrqLevelMode = {3{state_r == ST_PDOWN}} &
                            enable_r[EXIE_LSB +: 3];
   assign sysClockDivSel = clkSel_r[DIV_LSB +: 3];
   assign slowMode       = (clkSel_r[DIV_LSB +: 3] != 3'h0);
   assign oscSourceSel   = clkSel_r[OSC_LSB +: 2];
   assign subClockMode   = (clkSel_r[OSC_LSB +: 2] == OSC_LOW_SPEED);
   assign lowSpeedOscEn  = subClockMode | enable_r[WDEN_BIT];

   // APB read mux, registered
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (rdEn && !penable) begin
         unique case (paddr)
            MODE_OFS:   prdata <= {30'h0, modeReq_r};
            FLAG_OFS:   prdata <= {29'h0, flags_r};
            BODCTL_OFS: prdata <= {24'h0, bodCtl_r};
            ENABLE_OFS: prdata <= {20'h0, enable_r};
            CLKSEL_OFS: prdata <= {26'h0, clkSel_r};
            STATE_OFS:  prdata <= {28'h0, state_r};
            default:    prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Flag checks
   chk_fixed_flag_sets: assert property (
      @(posedge sys_clk) disable iff (srst)
      fixedDetTrip |=> flags_r[FBF_BIT])
      else $error("fixed flag not set");

   chk_zero_write_keeps: assert property (
      @(posedge sys_clk) disable iff (srst)
      flags_r[FBF_BIT] && !fixedDetTrip && !(wrEn && paddr == FLAG_OFS &&
      pwdata[FBF_BIT]) |=> flags_r[FBF_BIT])
      else $error("flag lost without clear");

   chk_sel_flag_sets: assert property (
      @(posedge sys_clk) disable iff (srst)
      selTrip && selActive |=> flags_r[SBF_BIT])
      else $error("selectable flag not set");

   chk_sel_flag_clear: assert property (
      @(posedge sys_clk) disable iff (srst)
      wrEn && paddr == FLAG_OFS && pwdata[SBF_BIT] && !(selTrip && selActive)
      |=> !flags_r[SBF_BIT])
      else $error("selectable flag not cleared");

   chk_sel_off_quiet: assert property (
      @(posedge sys_clk) disable iff (srst)
      !bodCtl_r[SDEN_BIT] && !flags_r[SBF_BIT] |=> !flags_r[SBF_BIT])
      else $error("disabled detector set flag");

   // Reset and interrupt checks
   chk_fixed_reset: assert property (
      @(posedge sys_clk) disable iff (srst)
      fixedDetTrip && bodCtl_r[FBRE_BIT] |=> sysResetReq)
      else $error("fixed reset missing");

   chk_sel_reset: assert property (
      @(posedge sys_clk) disable iff (srst)
      selTrip && selActive && bodCtl_r[SBRE_BIT] |=> sysResetReq)
      else $error("selectable reset missing");

   chk_irq_gate: assert property (
      @(posedge sys_clk) disable iff (srst)
      sysFlagIrq |-> enable_r[SFIE_BIT])
      else $error("irq without global enable");

   // Power state and slow mode checks
   chk_idle_clk_off: assert property (
      @(posedge sys_clk) disable iff (srst)
      state_r == ST_IDLE |-> !cpuClkEn && oscEnable)
      else $error("clock wrong in idle");

   chk_idle_exit: assert property (
      @(posedge sys_clk) disable iff (srst)
      state_r == ST_IDLE && anyIrq |=> state_r == ST_RUN && cpuClkEn)
      else $error("idle not left on interrupt");

   chk_pd_osc_off: assert property (
      @(posedge sys_clk) disable iff (srst)
      state_r == ST_PDOWN |-> !oscEnable && !flashPowerOn)
      else $error("oscillator on in power-down");

   chk_slow_mode: assert property (
      @(posedge sys_clk) disable iff (srst)
      slowMode == (sysClockDivSel != 3'h0))
      else $error("slow mode mismatch");

   chk_pd_exit: assert property (
      @(posedge sys_clk) disable iff (srst)
      state_r == ST_PDOWN && !pdWake && !resetRise |=> state_r == ST_PDOWN)
      else $error("power-down left without source");

   // Restart timer checks
   chk_wake_gated: assert property (
      @(posedge sys_clk) disable iff (srst)
      $rose(state_r == ST_WAKE) |-> !cpuClkEn [*8])
      else $error("clock leaked during restart");

   chk_wake_done: assert property (
      @(posedge sys_clk) disable iff (srst)
      state_r == ST_WAKE && wakeDone && !resetPin |=> cpuClkEn)
      else $error("clock not restored after timer");

   chk_pin_holds_wake: assert property (
      @(posedge sys_clk) disable iff (srst)
      state_r == ST_WAKE && resetPin |=> !cpuClkEn)
      else $error("ran while reset pin high");
endmodule : power_mode_and_brownout_control
`default_nettype wire
